// >>> inc/homing_supervisor_defs.vh
// Constants for the homing position supervisor
`ifndef HOMING_SUPERVISOR_DEFS_VH
`define HOMING_SUPERVISOR_DEFS_VH

// ****************************************************************
// Parameter object indices
// ****************************************************************
`define IDX_FOLLOWING_ERROR_WINDOW  16'h6065
`define IDX_FOLLOWING_ERROR_TIMEOUT 16'h6066
`define IDX_HOME_OFFSET_DISTANCE    16'h607C
`define IDX_MAX_PROFILE_VELOCITY    16'h607F
`define IDX_POSITION_CALC_METHOD    16'h60E6

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FOLLOWING_ERROR_WINDOW  32'h0030_0000
`define RST_FOLLOWING_ERROR_TIMEOUT 16'h0000
`define RST_HOME_OFFSET_DISTANCE    32'h0000_0000
`define RST_MAX_PROFILE_VELOCITY    32'h0640_0000
`define RST_POSITION_CALC_METHOD    8'h00
`define WINDOW_CEILING              32'h7FFF_FFFF

// ****************************************************************
// Field positions and encodings
// ****************************************************************
`define STATUS_HOMED_BIT            15
`define CALC_ABSOLUTE               8'h00
`define CALC_RELATIVE               8'h01

// Operation mode codes
`define MODE_PROFILE_POSITION       8'h01
`define MODE_PROFILE_VELOCITY       8'h03
`define MODE_PROFILE_TORQUE         8'h04
`define MODE_HOMING                 8'h06
`define MODE_CYCLIC_POSITION        8'h08
`define MODE_CYCLIC_TORQUE          8'h0A

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS               10
`define MS_NS                       1000000
// Cycles in one millisecond at the 10 ns clock, sized for the tick counter
`define CYCLES_PER_MS               17'h186A0

`endif

// >>> hw/param_store.v
// Parameter object store: writable registers with read data registered
`timescale 1ns/100ps
`include "homing_supervisor_defs.vh"

module param_store (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        wr_en_i,
  input  wire [15:0] wr_index_i,
  input  wire [31:0] wr_data_i,
  input  wire        calc_lock_i,
  input  wire        rd_en_i,
  input  wire [15:0] rd_index_i,
  output reg  [31:0] rd_data_o,
  output reg         rd_hit_o,
  output reg  [31:0] fe_window_o,
  output reg  [15:0] fe_timeout_o,
  output reg  [31:0] home_offset_o,
  output reg  [31:0] max_velocity_o,
  output reg  [7:0]  calc_method_o
);

  // ****************************************************************
  // Writes
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      fe_window_o    <= `RST_FOLLOWING_ERROR_WINDOW;
      fe_timeout_o   <= `RST_FOLLOWING_ERROR_TIMEOUT;
      home_offset_o  <= `RST_HOME_OFFSET_DISTANCE;
      max_velocity_o <= `RST_MAX_PROFILE_VELOCITY;
      calc_method_o  <= `RST_POSITION_CALC_METHOD;
    end else if (wr_en_i) begin
      case (wr_index_i)
        `IDX_FOLLOWING_ERROR_WINDOW: begin
          if (wr_data_i > `WINDOW_CEILING)
            fe_window_o <= `WINDOW_CEILING;
          else
            fe_window_o <= wr_data_i;
        end
        `IDX_FOLLOWING_ERROR_TIMEOUT: fe_timeout_o <= wr_data_i[15:0];
        `IDX_HOME_OFFSET_DISTANCE:    home_offset_o <= wr_data_i;
        `IDX_MAX_PROFILE_VELOCITY:    max_velocity_o <= wr_data_i;
        `IDX_POSITION_CALC_METHOD: begin
          if (!calc_lock_i)
            calc_method_o <= wr_data_i[7:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registered read port
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= 32'h0000_0000;
      rd_hit_o  <= 1'b0;
    end else begin
      rd_hit_o <= rd_en_i;
      case (rd_index_i)
        `IDX_FOLLOWING_ERROR_WINDOW:  rd_data_o <= fe_window_o;
        `IDX_FOLLOWING_ERROR_TIMEOUT: rd_data_o <= {16'h0000, fe_timeout_o};
        `IDX_HOME_OFFSET_DISTANCE:    rd_data_o <= home_offset_o;
        `IDX_MAX_PROFILE_VELOCITY:    rd_data_o <= max_velocity_o;
        `IDX_POSITION_CALC_METHOD:    rd_data_o <= {24'h000000, calc_method_o};
        default:                      rd_data_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // param_store

// >>> hw/homing_position_supervisor.v
// Homing position supervisor: position set, offset check, deviation, speed
`timescale 1ns/100ps
`include "homing_supervisor_defs.vh"

module homing_position_supervisor (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        param_wr_i,
  input  wire [15:0] param_wr_index_i,
  input  wire [31:0] param_wr_data_i,
  input  wire        param_rd_i,
  input  wire [15:0] param_rd_index_i,
  input  wire [7:0]  op_mode_i,
  input  wire        homing_start_i,
  input  wire        homing_done_i,
  input  wire [31:0] position_feedback_i,
  input  wire [31:0] position_deviation_i,
  input  wire [31:0] sw_limit_min_i,
  input  wire [31:0] sw_limit_max_i,
  input  wire [31:0] motor_max_speed_i,
  input  wire [31:0] speed_command_i,
  input  wire        fault_clear_i,
  output reg  [31:0] param_rd_data_o,
  output reg         param_rd_valid_o,
  output reg  [31:0] position_actual_o,
  output reg  [15:0] status_word_o,
  output reg         homing_active_o,
  output reg  [31:0] speed_limited_o,
  output reg         improper_home_offset_fault_o,
  output reg         excessive_deviation_fault_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_HOMING = 2'd1;
  localparam [1:0] ST_HOMED  = 2'd2;

  localparam [16:0] MS_TICKS = `CYCLES_PER_MS;

  // Mode codes in which the profile velocity limit applies
  localparam [39:0] LIMIT_MODES = {`MODE_PROFILE_POSITION,
                                   `MODE_PROFILE_VELOCITY,
                                   `MODE_PROFILE_TORQUE,
                                   `MODE_HOMING,
                                   `MODE_CYCLIC_TORQUE};

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [16:0] tick_cnt_reg;
  reg         ms_tick_reg;
  reg  [16:0] ms_cnt_reg;
  reg         homed_reg;
  reg  [31:0] offset_pos_reg;
  reg         dev_over_reg;

  // Parameter values held by the store
  wire [31:0] fe_window;
  wire [15:0] fe_timeout;
  wire [31:0] home_offset;
  wire [31:0] max_velocity;
  wire [7:0]  calc_method;
  wire [31:0] rd_data;
  wire        rd_hit;
  wire        calc_lock;
  wire [31:0] dev_mag;
  wire        dev_over;
  wire        offset_bad;
  wire        limit_mode;
  wire [31:0] eff_limit;
  wire [31:0] speed_mag;
  wire        speed_neg;
  wire [31:0] pos_next;
  wire [31:0] neg_limit;
  wire [4:0]  mode_hit;
  wire        start_taken;
  wire        done_taken;

  genvar      gi;

  // ****************************************************************
  // Parameter store
  // ****************************************************************
  param_store param_store_i (
    .clk_i          (clk_i),
    .srst_i         (srst_i),
    .wr_en_i        (param_wr_i),
    .wr_index_i     (param_wr_index_i),
    .wr_data_i      (param_wr_data_i),
    .calc_lock_i    (calc_lock),
    .rd_en_i        (param_rd_i),
    .rd_index_i     (param_rd_index_i),
    .rd_data_o      (rd_data),
    .rd_hit_o       (rd_hit),
    .fe_window_o    (fe_window),
    .fe_timeout_o   (fe_timeout),
    .home_offset_o  (home_offset),
    .max_velocity_o (max_velocity),
    .calc_method_o  (calc_method)
  );

  // Selector is locked from the trigger until the end of homing
  assign calc_lock = (state_reg == ST_HOMING) | homing_start_i;

  // ****************************************************************
  // Homing events
  // ****************************************************************
  // Trigger taken from idle or homed; done only counts while homing
  assign start_taken = homing_start_i & (state_reg != ST_HOMING);
  assign done_taken  = homing_done_i & (state_reg == ST_HOMING);

  // ****************************************************************
  // Homing sequence state
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Waits for the first trigger after reset
        if (start_taken)
          state_next = ST_HOMING;
      end
      ST_HOMING: begin
        // Method sequence runs outside; only its end is seen here
        if (done_taken)
          state_next = ST_HOMED;
      end
      ST_HOMED: begin
        // A new trigger starts another run and drops the homed flag
        if (start_taken)
          state_next = ST_HOMING;
      end
      default:   state_next = ST_IDLE;
    endcase
  end

  // Actual position formula by method
  assign pos_next = (calc_method == `CALC_RELATIVE) ?
                    position_feedback_i + home_offset : home_offset;

  // State, homed flag and the position latched at the end of homing
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg       <= ST_IDLE;
      homed_reg       <= 1'b0;
      offset_pos_reg  <= 32'h0000_0000;
      homing_active_o <= 1'b0;
    end else begin
      state_reg       <= state_next;
      homing_active_o <= (state_next == ST_HOMING);
      if (done_taken) begin
        homed_reg      <= 1'b1;
        offset_pos_reg <= pos_next;
      end else if (start_taken) begin
        homed_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Reported position and status
  // ****************************************************************
  // Bit 15 mirrors the homed flag one cycle later
  always @(posedge clk_i) begin
    if (srst_i) begin
      position_actual_o <= 32'h0000_0000;
      status_word_o     <= 16'h0000;
    end else begin
      status_word_o                  <= 16'h0000;
      status_word_o[`STATUS_HOMED_BIT] <= homed_reg;
      // Offset-based position only once homed flag is up
      if (homed_reg && status_word_o[`STATUS_HOMED_BIT])
        position_actual_o <= offset_pos_reg;
      else
        position_actual_o <= position_feedback_i;
    end
  end

  // ****************************************************************
  // Home offset range check against software limits
  // ****************************************************************
  // Signed compare; passing either limit is a violation
  assign offset_bad = ($signed(home_offset) < $signed(sw_limit_min_i)) |
                      ($signed(home_offset) > $signed(sw_limit_max_i));

  // Sticky fault; a standing violation beats the clear
  always @(posedge clk_i) begin
    if (srst_i)
      improper_home_offset_fault_o <= 1'b0;
    else if (offset_bad)
      improper_home_offset_fault_o <= 1'b1;
    else if (fault_clear_i)
      improper_home_offset_fault_o <= 1'b0;
  end

  // ****************************************************************
  // Following error watchdog
  // ****************************************************************
  assign dev_mag  = position_deviation_i[31] ?
                    (~position_deviation_i + 32'h0000_0001) :
                    position_deviation_i;
  assign dev_over = dev_mag > fe_window;

  // Compare registered to keep subtract and compare off the counter
  // paths; adds one cycle to the persistence time
  always @(posedge clk_i) begin
    if (srst_i)
      dev_over_reg <= 1'b0;
    else
      dev_over_reg <= dev_over;
  end

  // Millisecond tick generator
  always @(posedge clk_i) begin
    if (srst_i || !dev_over_reg) begin
      tick_cnt_reg <= 17'h00000;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == MS_TICKS - 17'h00001) begin
      tick_cnt_reg <= 17'h00000;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      ms_tick_reg  <= 1'b0;
    end
  end

  // Elapsed milliseconds of continuous excess deviation
  always @(posedge clk_i) begin
    if (srst_i || !dev_over_reg)
      ms_cnt_reg <= 17'h00000;
    else if (ms_tick_reg && ms_cnt_reg <= {1'b0, fe_timeout})
      ms_cnt_reg <= ms_cnt_reg + 17'h00001;
  end

  // Fault sets when persistence passes the timeout
  always @(posedge clk_i) begin
    if (srst_i)
      excessive_deviation_fault_o <= 1'b0;
    else if (dev_over_reg && ms_cnt_reg > {1'b0, fe_timeout})
      excessive_deviation_fault_o <= 1'b1;
    else if (fault_clear_i)
      excessive_deviation_fault_o <= 1'b0;
  end

  // ****************************************************************
  // Speed limit
  // ****************************************************************
  // One comparator per listed mode code
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_mode
      assign mode_hit[gi] = (op_mode_i == LIMIT_MODES[8*gi +: 8]);
    end
  endgenerate

  // A homing run is limited whatever mode code stands beside it
  assign limit_mode = (|mode_hit) | homing_active_o;
  assign eff_limit  = (max_velocity > motor_max_speed_i) ?
                      motor_max_speed_i : max_velocity;

  // Sign and magnitude of the command, and the negated limit
  assign speed_neg  = speed_command_i[31];
  assign speed_mag  = speed_neg ? (~speed_command_i + 32'h0000_0001) :
                      speed_command_i;
  assign neg_limit  = ~eff_limit + 32'h0000_0001;

  // Clamp magnitude in both directions
  always @(posedge clk_i) begin
    if (srst_i)
      speed_limited_o <= 32'h0000_0000;
    else if (limit_mode && speed_mag > eff_limit)
      speed_limited_o <= speed_neg ? neg_limit : eff_limit;
    else
      speed_limited_o <= speed_command_i;
  end

  // ****************************************************************
  // Parameter read answer
  // ****************************************************************
  // Second stage of the read pipeline
  always @(posedge clk_i) begin
    if (srst_i) begin
      param_rd_data_o  <= 32'h0000_0000;
      param_rd_valid_o <= 1'b0;
    end else begin
      param_rd_data_o  <= rd_data;
      param_rd_valid_o <= rd_hit;
    end
  end

endmodule // homing_position_supervisor

// >>> verif/homing_position_supervisor_monitor.sv
// Assertion checker for the homing position supervisor
`timescale 1ns/100ps
module homing_position_supervisor_monitor (
  input wire        clk_i,
  input wire        srst_i,
  input wire        param_rd_i,
  input wire        homing_start_i,
  input wire        homing_done_i,
  input wire [7:0]  op_mode_i,
  input wire [31:0] position_feedback_i,
  input wire [31:0] motor_max_speed_i,
  input wire [31:0] speed_command_i,
  input wire [31:0] position_deviation_i,
  input wire        fault_clear_i,
  input wire        param_rd_valid_o,
  input wire [31:0] position_actual_o,
  input wire [15:0] status_word_o,
  input wire        homing_active_o,
  input wire [31:0] speed_limited_o,
  input wire        improper_home_offset_fault_o,
  input wire        excessive_deviation_fault_o
);
  reg started;

  // Magnitude of a signed speed
  function [31:0] mag(input [31:0] v);
    mag = v[31] ? -v : v;
  endfunction

  // Remembers that a homing run has begun since reset
  always @(posedge clk_i) begin
    started <= srst_i ? 1'b0 : (started | homing_active_o);
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_read_answer_lat: assert property (param_rd_i |-> ##2 param_rd_valid_o)
    else $error("read answer late");
  a_valid_has_read: assert property (param_rd_valid_o |-> $past(param_rd_i, 2))
    else $error("read answer without request");
  a_start_goes_active: assert property (
    homing_start_i && !homing_active_o |=> homing_active_o)
    else $error("homing not started");
  a_done_sets_homed: assert property (
    homing_active_o && homing_done_i |-> ##2 status_word_o[15])
    else $error("homed flag late");
  a_done_ends_run: assert property (
    homing_active_o && homing_done_i |=> !homing_active_o
    && !status_word_o[15]) else $error("bad end");
  a_status_only_homed: assert property (
    status_word_o[14:0] == 15'h0000) else $error("stray status bits");
  a_pos_follows_fb: assert property (
    !started && $past(!srst_i)
    |-> position_actual_o == $past(position_feedback_i))
    else $error("position not following");
  a_homing_speed_clamped: assert property (
    $past(op_mode_i) == 8'h06 && $past(!srst_i)
    |-> mag(speed_limited_o) <= $past(motor_max_speed_i))
    else $error("speed above motor limit");
  a_unlisted_speed_passes: assert property (
    $past(op_mode_i) == 8'h08 && $past(!homing_active_o) && $past(!srst_i)
    |-> speed_limited_o == $past(speed_command_i))
    else $error("speed altered");
  a_offset_fault_sticks: assert property (
    improper_home_offset_fault_o && !fault_clear_i
    |=> improper_home_offset_fault_o) else $error("offset fault dropped");
  a_dev_fault_sticks: assert property (
    excessive_deviation_fault_o && !fault_clear_i
    |=> excessive_deviation_fault_o) else $error("deviation fault dropped");
  a_dev_fault_needs_dev: assert property (
    $rose(excessive_deviation_fault_o)
    |-> $past(position_deviation_i, 2) != 32'h0000_0000)
    else $error("deviation fault without deviation");
endmodule // homing_position_supervisor_monitor

bind homing_position_supervisor homing_position_supervisor_monitor monitor_i (
  .clk_i(clk_i), .srst_i(srst_i), .param_rd_i(param_rd_i),
  .homing_start_i(homing_start_i), .homing_done_i(homing_done_i),
  .op_mode_i(op_mode_i), .position_feedback_i(position_feedback_i),
  .motor_max_speed_i(motor_max_speed_i), .speed_command_i(speed_command_i),
  .position_deviation_i(position_deviation_i),
  .fault_clear_i(fault_clear_i), .param_rd_valid_o(param_rd_valid_o),
  .position_actual_o(position_actual_o), .status_word_o(status_word_o),
  .homing_active_o(homing_active_o), .speed_limited_o(speed_limited_o),
  .improper_home_offset_fault_o(improper_home_offset_fault_o),
  .excessive_deviation_fault_o(excessive_deviation_fault_o));

// >>> verif/host_param_master.sv
// Host controller model writing and reading parameter objects
`timescale 1ns/100ps
module host_param_master (
  input  wire        clk_i,
  input  wire [31:0] rd_data_i,
  input  wire        rd_valid_i,
  output reg         wr_o,
  output reg  [15:0] wr_index_o,
  output reg  [31:0] wr_data_o,
  output reg         rd_o,
  output reg  [15:0] rd_index_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    wr_index_o = 16'h0000;
    wr_data_o = 32'h0000_0000;
    rd_o = 1'b0;
    rd_index_o = 16'h0000;
  end

  // One-cycle write strobe; released fields show inverted garbage
  task wr_obj(input [15:0] idx, input [31:0] d);
    begin
      @(negedge clk_i);
      wr_o = 1'b1;
      wr_index_o = idx;
      wr_data_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      wr_index_o = ~idx;
      wr_data_o = ~d;
    end
  endtask

  // Read strobe, answer one edge after the edge that takes it
  task rd_obj(input [15:0] idx, output [31:0] d, output v);
    begin
      @(negedge clk_i);
      rd_o = 1'b1;
      rd_index_o = idx;
      @(negedge clk_i);
      rd_o = 1'b0;
      rd_index_o = ~idx;
      @(posedge clk_i);
      @(negedge clk_i);
      d = rd_data_i;
      v = rd_valid_i;
    end
  endtask
endmodule // host_param_master

// >>> verif/homing_position_supervisor_test.sv
// Self-checking bench for the homing position supervisor
`timescale 1ns/100ps
`include "homing_supervisor_defs.vh"
module homing_position_supervisor_test;
  reg         clk_i;
  reg         srst_i;
  reg  [7:0]  op_mode;
  reg         start;
  reg         done;
  reg  [31:0] fb;
  reg  [31:0] dev;
  reg  [31:0] motor;
  reg  [31:0] cmd;
  reg  [31:0] lim_min;
  reg  [31:0] lim_max;
  reg         clr;
  reg  [31:0] d;
  reg         v;
  reg  [47:0] modes;
  integer     k;
  integer     n_fail;
  integer     compares;
  wire        wr_str;
  wire        rd;
  wire        rd_valid;
  wire        active;
  wire        f_off;
  wire        f_dev;
  wire [15:0] wr_idx;
  wire [15:0] rd_idx;
  wire [15:0] status;
  wire [31:0] wr_data;
  wire [31:0] rd_data;
  wire [31:0] pos;
  wire [31:0] speed;

  homing_position_supervisor homing_position_supervisor_i (
    .clk_i(clk_i), .srst_i(srst_i), .param_wr_i(wr_str),
    .param_wr_index_i(wr_idx), .param_wr_data_i(wr_data),
    .param_rd_i(rd), .param_rd_index_i(rd_idx), .op_mode_i(op_mode),
    .homing_start_i(start), .homing_done_i(done),
    .position_feedback_i(fb), .position_deviation_i(dev),
    .sw_limit_min_i(lim_min), .sw_limit_max_i(lim_max),
    .motor_max_speed_i(motor), .speed_command_i(cmd), .fault_clear_i(clr),
    .param_rd_data_o(rd_data), .param_rd_valid_o(rd_valid),
    .position_actual_o(pos), .status_word_o(status),
    .homing_active_o(active), .speed_limited_o(speed),
    .improper_home_offset_fault_o(f_off),
    .excessive_deviation_fault_o(f_dev));

  host_param_master host_param_master_i (
    .clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .wr_o(wr_str), .wr_index_o(wr_idx), .wr_data_o(wr_data),
    .rd_o(rd), .rd_index_o(rd_idx));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task rchk(input [15:0] idx, input [31:0] exp);
    begin
      host_param_master_i.rd_obj(idx, d, v);
      chk({31'h0, v}, 32'h1);
      chk(d, exp);
    end
  endtask

  task wr(input [15:0] idx, input [31:0] val);
    host_param_master_i.wr_obj(idx, val);
  endtask

  // Pulse an input for one cycle then let the pipeline settle
  task home(input integer settle);
    begin
      start = 1'b1;
      @(negedge clk_i);
      start = 1'b0;
      repeat (settle) @(negedge clk_i);
    end
  endtask

  task stop_test;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Watchdog
  initial begin
    #20000;
    n_fail = n_fail + 1;
    stop_test;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    n_fail = 0;
    compares = 0;
    srst_i = 1'b1;
    op_mode = 8'h08;
    start = 1'b0;
    done = 1'b0;
    fb = 32'h0000_03E8;
    dev = 32'h0000_0000;
    motor = 32'h0000_00C8;
    cmd = 32'hFFFF_FE0C;
    clr = 1'b0;
    lim_min = 32'hFFFF_F000;
    lim_max = 32'h0000_1000;
    modes = 48'h01_03_04_06_08_0A;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    rchk(`IDX_FOLLOWING_ERROR_WINDOW, `RST_FOLLOWING_ERROR_WINDOW);
    rchk(`IDX_FOLLOWING_ERROR_TIMEOUT, 32'h0000_0000);
    rchk(`IDX_HOME_OFFSET_DISTANCE, `RST_HOME_OFFSET_DISTANCE);
    rchk(`IDX_MAX_PROFILE_VELOCITY, `RST_MAX_PROFILE_VELOCITY);
    rchk(`IDX_POSITION_CALC_METHOD, 32'h0000_0000);
    rchk(16'h6067, 32'h0000_0000);
    wr(`IDX_FOLLOWING_ERROR_WINDOW, 32'hFFFF_FFFF);
    rchk(`IDX_FOLLOWING_ERROR_WINDOW, `WINDOW_CEILING);
    wr(`IDX_FOLLOWING_ERROR_WINDOW, 32'h8000_0000);
    rchk(`IDX_FOLLOWING_ERROR_WINDOW, `WINDOW_CEILING);
    wr(`IDX_FOLLOWING_ERROR_TIMEOUT, 32'h0000_FFFF);
    rchk(`IDX_FOLLOWING_ERROR_TIMEOUT, 32'h0000_FFFF);
    wr(`IDX_MAX_PROFILE_VELOCITY, 32'h0000_0064);
    for (k = 0; k < 6; k = k + 1) begin
      op_mode = modes[8*k +: 8];
      repeat (2) @(negedge clk_i);
      chk(speed, op_mode == 8'h08 ? cmd : 32'hFFFF_FF9C);
    end
    op_mode = 8'h06;
    motor = 32'h0000_0032;
    cmd = 32'h0000_01F4;
    repeat (2) @(negedge clk_i);
    chk(speed, 32'h0000_0032);
    op_mode = 8'h08;
    chk(pos, fb);
    wr(`IDX_HOME_OFFSET_DISTANCE, 32'h0000_0234);
    home(1);
    wr(`IDX_POSITION_CALC_METHOD, 32'h0000_0001);
    rchk(`IDX_POSITION_CALC_METHOD, 32'h0000_0000);
    chk({16'h0, status}, 32'h0000_0000);
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({16'h0, status}, 32'h0000_8000);
    chk(pos, 32'h0000_0234);
    wr(`IDX_POSITION_CALC_METHOD, 32'h0000_0001);
    wr(`IDX_HOME_OFFSET_DISTANCE, 32'hFFFF_FFFB);
    home(2);
    chk({16'h0, status}, 32'h0000_0000);
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    repeat (5) @(negedge clk_i);
    chk(pos, 32'h0000_03E3);
    fb = 32'h0000_0500;
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(pos, 32'h0000_03E3);
    chk({31'h0, f_off}, 32'h0);
    wr(`IDX_HOME_OFFSET_DISTANCE, 32'h0000_2000);
    repeat (2) @(negedge clk_i);
    chk({31'h0, f_off}, 32'h1);
    clr = 1'b1;
    wr(`IDX_HOME_OFFSET_DISTANCE, 32'h0000_0000);
    repeat (2) @(negedge clk_i);
    clr = 1'b0;
    chk({31'h0, f_off}, 32'h0);
    wr(`IDX_HOME_OFFSET_DISTANCE, 32'hFFFF_E000);
    repeat (2) @(negedge clk_i);
    chk({31'h0, f_off}, 32'h1);
    lim_min = 32'hFFFF_0000;
    clr = 1'b1;
    repeat (2) @(negedge clk_i);
    clr = 1'b0;
    chk({31'h0, f_off}, 32'h0);
    lim_max = 32'hFFFF_D000;
    repeat (2) @(negedge clk_i);
    chk({31'h0, f_off}, 32'h1);
    wr(`IDX_FOLLOWING_ERROR_WINDOW, 32'h0000_0010);
    rchk(`IDX_FOLLOWING_ERROR_WINDOW, 32'h0000_0010);
    dev = 32'hFFFF_FFE0;
    repeat (200) @(negedge clk_i);
    chk({31'h0, f_dev}, 32'h0);
    dev = 32'h0000_0000;
    stop_test;
  end
endmodule // homing_position_supervisor_test
